// ===== npc_cs_decode.sv
// Chip-select decoder and pin driver for one pin of the nibble port
`include "npc_defs.svh"
module npc_cs_decode (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire npc_pkg::npc_pin_cfg_t i_cfg,
   input wire logic [15:0] i_base,
   input wire npc_pkg::npc_bus_t i_bus,
   input wire logic i_invert,
   input wire logic i_data,
   output logic o_pin_out,
   output logic o_pin_oe
);
   logic [15:0] mask;
   logic match;
   logic active;
   logic hit;

   always_comb begin
      unique case (i_cfg.cmp)
         npc_pkg::NPC_CMP_FULL: mask = `NPC_MASK_FULL;
         npc_pkg::NPC_CMP_A1: mask = `NPC_MASK_A1;
         npc_pkg::NPC_CMP_A2: mask = `NPC_MASK_A2;
         npc_pkg::NPC_CMP_A8: mask = `NPC_MASK_A8;
      endcase
   end

   assign match = ((i_bus.addr ^ i_base) & mask) == 16'h0000;

   always_comb begin
      unique case (i_cfg.func)
         npc_pkg::NPC_FUNC_GPIO: active = 1'b0;
         npc_pkg::NPC_FUNC_RD: active = !i_bus.rd_n;
         npc_pkg::NPC_FUNC_WR: active = !i_bus.wr_n;
         npc_pkg::NPC_FUNC_RW: active = !i_bus.rd_n || !i_bus.wr_n;
      endcase
   end

   assign hit = active && match;

   // One cycle of lag behind the bus strobes, traded for a clean flopped pin
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_pin_out <= 1'b0;
         o_pin_oe <= 1'b0;
      end else if (i_cfg.func == npc_pkg::NPC_FUNC_GPIO) begin
         o_pin_out <= 1'b0;
         o_pin_oe <= !i_data;
      end else begin
         o_pin_out <= hit ^ !i_invert;
         o_pin_oe <= 1'b1;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   property p_rd_strobe;
      (i_cfg.func == npc_pkg::NPC_FUNC_RD && match && !i_bus.rd_n)
         |=> (o_pin_out == $past(i_invert)) && o_pin_oe;
   endproperty
   a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe not asserted");

   property p_wr_strobe;
      (i_cfg.func == npc_pkg::NPC_FUNC_WR && match && !i_bus.wr_n)
         |=> (o_pin_out == $past(i_invert));
   endproperty
   a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe not asserted");

   property p_rw_idle;
      (i_cfg.func == npc_pkg::NPC_FUNC_RW && (!match || (i_bus.rd_n && i_bus.wr_n)))
         |=> (o_pin_out != $past(i_invert)) && o_pin_oe;
   endproperty
   a_rw_idle: assert property (p_rw_idle) else $error("strobe active without a hit");

   property p_gpio_drive;
      (i_cfg.func == npc_pkg::NPC_FUNC_GPIO) |=> (o_pin_oe == !$past(i_data)) && !o_pin_out;
   endproperty
   a_gpio_drive: assert property (p_gpio_drive) else $error("gpio pin drive wrong");

   c_rw_strobe: cover property (i_cfg.func == npc_pkg::NPC_FUNC_RW && hit ##1 o_pin_oe);
endmodule

// ===== npc_defs.svh
// Register indices, field positions, reset values and fixed codes of the nibble port
`ifndef NPC_DEFS_SVH
`define NPC_DEFS_SVH

// Register indices; byte address on the bus is four times the index
`define NPC_IDX_EXT_IRQ_CONTROL 10'h0C0
`define NPC_IDX_CFG_LOW_PINS 10'h0C2
`define NPC_IDX_CFG_HIGH_PINS 10'h0C3
`define NPC_IDX_NIBBLE_PORT_DATA 10'h0D8
`define NPC_IDX_STROBE_POLARITY 10'h0AE
`define NPC_IDX_BASE_LOW_PIN0 10'h084
`define NPC_IDX_BASE_HIGH_PIN0 10'h085
`define NPC_IDX_BASE_LOW_PIN1 10'h094
`define NPC_IDX_BASE_HIGH_PIN1 10'h095
`define NPC_IDX_BASE_LOW_PIN2 10'h0AC
`define NPC_IDX_BASE_HIGH_PIN2 10'h0AD
`define NPC_IDX_BASE_LOW_PIN3 10'h0B4
`define NPC_IDX_BASE_HIGH_PIN3 10'h0B5
// Single-bit window onto the interrupt control register, one word per bit
`define NPC_IDX_BIT_WINDOW 10'h100
`define NPC_BIT_WINDOW_MASK 10'h3F8

// Interrupt control fields; second source at offset 0, third at offset 4
`define NPC_XC_TRIGGER 0
`define NPC_XC_PENDING 1
`define NPC_XC_ENABLE 2
`define NPC_XC_PRIORITY 3
`define NPC_XC_STRIDE 4

// Strobe polarity bits start here, one per pin
`define NPC_POL_LSB 4
`define NPC_PORT_DATA_RST 4'hF
`define NPC_CFG_RST 8'h00

// Vectors, and polling positions within a priority level
`define NPC_VEC_SECOND 8'h33
`define NPC_VEC_THIRD 8'h3B
`define NPC_VEC_NONE 8'h00
`define NPC_POLL_SECOND 3'h6
`define NPC_POLL_THIRD 3'h7

// Compare masks per compare-length code
`define NPC_MASK_FULL 16'hFFFF
`define NPC_MASK_A1 16'hFFFE
`define NPC_MASK_A2 16'hFFFC
`define NPC_MASK_A8 16'hFF00

`define NPC_RESP_OKAY 2'h0
`define NPC_RESP_SLVERR 2'h2

`endif

// ===== npc_nibble_port.sv
// Nibble port with chip-select strobes, two added interrupts and an AXI4-Lite register slave
//
// Notes on behaviour
// - Four pins, each set by its own two-bit function field.
// - Function 00 is plain port I/O; pins two and three feed interrupts.
// - Function 01 drives a read strobe while the address is in range.
// - Function 10 drives a write strobe while the address is in range.
// - Function 11 drives a strobe on read or write in range.
// - Each pin has a 16-bit base from a high and a low byte.
// - Compare length 00 compares all sixteen address bits.
// - Compare length 01 ignores address bit zero.
// - Compare length 10 ignores the two lowest address bits.
// - Compare length 11 ignores the low address byte.
// - High config register holds pin three fields above pin two fields.
// - A set priority bit raises that interrupt to high level.
// - Enables sit at bit 2 and bit 6 of interrupt control.
// - Trigger bit set means falling edge, clear means low level.
// - Edge sets the pending flag; servicing clears it.
// - Second interrupt vectors to 33h, polled sixth in its level.
// - Third interrupt vectors to 3Bh, polled last in its level.
// - Interrupt control bits can be set or cleared one at a time.
// - Strobes are active low unless the pin's polarity bit is set.
// - Port data bits 3:0 drive the pins in I/O mode.
//
// Register access over AXI4-Lite was chosen for this implementation.
`include "npc_defs.svh"
module npc_nibble_port #(
   parameter int NUM_PINS = 4
) (
   input wire logic I_SYS_CLK,
   input wire logic I_SRST,
   input wire logic [11:0] I_S_AXI_AWADDR,
   input wire logic I_S_AXI_AWVALID,
   output logic O_S_AXI_AWREADY,
   input wire logic [31:0] I_S_AXI_WDATA,
   input wire logic [3:0] I_S_AXI_WSTRB,
   input wire logic I_S_AXI_WVALID,
   output logic O_S_AXI_WREADY,
   output logic [1:0] O_S_AXI_BRESP,
   output logic O_S_AXI_BVALID,
   input wire logic I_S_AXI_BREADY,
   input wire logic [11:0] I_S_AXI_ARADDR,
   input wire logic I_S_AXI_ARVALID,
   output logic O_S_AXI_ARREADY,
   output logic [31:0] O_S_AXI_RDATA,
   output logic [1:0] O_S_AXI_RRESP,
   output logic O_S_AXI_RVALID,
   input wire logic I_S_AXI_RREADY,
   input wire logic [15:0] I_BUS_ADDR,
   input wire logic I_BUS_RD_N,
   input wire logic I_BUS_WR_N,
   input wire logic [3:0] I_PIN,
   output logic [3:0] O_PIN,
   output logic [3:0] O_PIN_OE,
   input wire logic [1:0] I_IRQ_SERVICED,
   output logic [1:0] O_IRQ_REQ,
   output logic [1:0] O_IRQ_HIGH_PRIO,
   output logic [7:0] O_IRQ_VECTOR
);
   // Register layout is fixed at four pins
   if (NUM_PINS != 4) begin : g_bad_pins
      $error("NUM_PINS must be 4");
   end

   localparam logic [9:0] BASE_LO_IDX [4] = '{`NPC_IDX_BASE_LOW_PIN0, `NPC_IDX_BASE_LOW_PIN1,
      `NPC_IDX_BASE_LOW_PIN2, `NPC_IDX_BASE_LOW_PIN3};
   localparam logic [9:0] BASE_HI_IDX [4] = '{`NPC_IDX_BASE_HIGH_PIN0, `NPC_IDX_BASE_HIGH_PIN1,
      `NPC_IDX_BASE_HIGH_PIN2, `NPC_IDX_BASE_HIGH_PIN3};

   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic [11:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic [9:0] wr_idx;
   logic [9:0] rd_idx;
   logic wr_fire;
   logic byte_wr;
   logic [7:0] rd_byte;

   logic [7:0] cfg_reg [2];
   logic [3:0] port_data_reg;
   logic [3:0] polarity_reg;
   logic [7:0] base_lo_reg [NUM_PINS];
   logic [7:0] base_hi_reg [NUM_PINS];
   logic [3:0] pin_meta_reg;
   logic [3:0] pin_sync_reg;
   npc_pkg::npc_pin_cfg_t pin_cfg [NUM_PINS];
   npc_pkg::npc_bus_t bus;

   logic it_reg [2];
   logic pend_reg [2];
   logic en_reg [2];
   logic px_reg [2];
   logic src_prev_reg [2];
   logic src_level [2];
   logic fall [2];
   logic req [2];
   logic [1:0] irq_req_reg;
   logic [1:0] irq_prio_reg;
   logic [7:0] vector_reg;
   logic [7:0] ext_irq_control_value;
   logic xc_wr_en;
   logic [7:0] xc_wr_val;

   function automatic logic is_mapped(input logic [9:0] idx);
      logic hit;
      hit = (idx == `NPC_IDX_EXT_IRQ_CONTROL) || (idx == `NPC_IDX_CFG_LOW_PINS) ||
         (idx == `NPC_IDX_CFG_HIGH_PINS) || (idx == `NPC_IDX_NIBBLE_PORT_DATA) ||
         (idx == `NPC_IDX_STROBE_POLARITY) ||
         ((idx & `NPC_BIT_WINDOW_MASK) == `NPC_IDX_BIT_WINDOW);
      for (int k = 0; k < 4; k++) begin
         if (idx == BASE_LO_IDX[k] || idx == BASE_HI_IDX[k]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // Write address and data are held independently, so either may come first
   assign wr_idx = aw_addr_reg[11:2];
   assign rd_idx = I_S_AXI_ARADDR[11:2];
   assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
   assign byte_wr = wr_fire && w_strb_reg[0];

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         awready_reg <= 1'b1;
         aw_addr_reg <= 12'h000;
      end else if (I_S_AXI_AWVALID && awready_reg) begin
         awready_reg <= 1'b0;
         aw_addr_reg <= I_S_AXI_AWADDR;
      end else if (bvalid_reg && I_S_AXI_BREADY) begin
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         wready_reg <= 1'b1;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else if (I_S_AXI_WVALID && wready_reg) begin
         wready_reg <= 1'b0;
         w_data_reg <= I_S_AXI_WDATA;
         w_strb_reg <= I_S_AXI_WSTRB;
      end else if (bvalid_reg && I_S_AXI_BREADY) begin
         wready_reg <= 1'b1;
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `NPC_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= is_mapped(wr_idx) ? `NPC_RESP_OKAY : `NPC_RESP_SLVERR;
      end else if (I_S_AXI_BREADY) begin
         bvalid_reg <= 1'b0;
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      if (rd_idx == `NPC_IDX_EXT_IRQ_CONTROL) begin
         rd_byte = ext_irq_control_value;
      end else if (rd_idx == `NPC_IDX_CFG_LOW_PINS) begin
         rd_byte = cfg_reg[0];
      end else if (rd_idx == `NPC_IDX_CFG_HIGH_PINS) begin
         rd_byte = cfg_reg[1];
      end else if (rd_idx == `NPC_IDX_NIBBLE_PORT_DATA) begin
         // Reads return the pin levels, as a port read does
         rd_byte = {4'h0, pin_sync_reg};
      end else if (rd_idx == `NPC_IDX_STROBE_POLARITY) begin
         rd_byte = {polarity_reg, 4'h0};
      end else if ((rd_idx & `NPC_BIT_WINDOW_MASK) == `NPC_IDX_BIT_WINDOW) begin
         rd_byte = {7'h00, ext_irq_control_value[rd_idx[2:0]]};
      end else begin
         for (int k = 0; k < NUM_PINS; k++) begin
            if (rd_idx == BASE_LO_IDX[k]) begin
               rd_byte = base_lo_reg[k];
            end
            if (rd_idx == BASE_HI_IDX[k]) begin
               rd_byte = base_hi_reg[k];
            end
         end
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `NPC_RESP_OKAY;
      end else if (I_S_AXI_ARVALID && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h00_0000, rd_byte};
         rresp_reg <= is_mapped(rd_idx) ? `NPC_RESP_OKAY : `NPC_RESP_SLVERR;
      end else if (rvalid_reg && I_S_AXI_RREADY) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         cfg_reg[0] <= `NPC_CFG_RST;
         cfg_reg[1] <= `NPC_CFG_RST;
      end else if (byte_wr && wr_idx == `NPC_IDX_CFG_LOW_PINS) begin
         cfg_reg[0] <= w_data_reg[7:0];
      end else if (byte_wr && wr_idx == `NPC_IDX_CFG_HIGH_PINS) begin
         cfg_reg[1] <= w_data_reg[7:0];
      end
   end

   // data nibble; upper bits are not stored
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         port_data_reg <= `NPC_PORT_DATA_RST;
      end else if (byte_wr && wr_idx == `NPC_IDX_NIBBLE_PORT_DATA) begin
         port_data_reg <= w_data_reg[3:0];
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         polarity_reg <= 4'h0;
      end else if (byte_wr && wr_idx == `NPC_IDX_STROBE_POLARITY) begin
         polarity_reg <= w_data_reg[`NPC_POL_LSB +: 4];
      end
   end

   // Pins come from outside; only the second stage is ever looked at
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         pin_meta_reg <= 4'hF;
         pin_sync_reg <= 4'hF;
      end else begin
         pin_meta_reg <= I_PIN;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign bus = '{addr: I_BUS_ADDR, rd_n: I_BUS_RD_N, wr_n: I_BUS_WR_N};

   for (genvar k = 0; k < NUM_PINS; k++) begin : g_pin
      // two fields per pin, higher pin in the upper nibble
      assign pin_cfg[k] = npc_pkg::npc_pin_cfg_t'(cfg_reg[k / 2][(k % 2) * 4 +: 4]);

      always_ff @(posedge I_SYS_CLK) begin
         if (I_SRST) begin
            base_lo_reg[k] <= 8'h00;
            base_hi_reg[k] <= 8'h00;
         end else if (byte_wr && wr_idx == BASE_LO_IDX[k]) begin
            base_lo_reg[k] <= w_data_reg[7:0];
         end else if (byte_wr && wr_idx == BASE_HI_IDX[k]) begin
            base_hi_reg[k] <= w_data_reg[7:0];
         end
      end

      npc_cs_decode u_decode (
         .i_clk(I_SYS_CLK),
         .i_srst(I_SRST),
         .i_cfg(pin_cfg[k]),
         .i_base({base_hi_reg[k], base_lo_reg[k]}),
         .i_bus(bus),
         .i_invert(polarity_reg[k]),
         .i_data(port_data_reg[k]),
         .o_pin_out(O_PIN[k]),
         .o_pin_oe(O_PIN_OE[k])
      );
   end

   assign ext_irq_control_value = {px_reg[1], en_reg[1], pend_reg[1], it_reg[1],
      px_reg[0], en_reg[0], pend_reg[0], it_reg[0]};

   // byte write or single-bit write through the window
   always_comb begin
      xc_wr_en = 1'b0;
      xc_wr_val = ext_irq_control_value;
      if (byte_wr && wr_idx == `NPC_IDX_EXT_IRQ_CONTROL) begin
         xc_wr_en = 1'b1;
         xc_wr_val = w_data_reg[7:0];
      end else if (byte_wr && (wr_idx & `NPC_BIT_WINDOW_MASK) == `NPC_IDX_BIT_WINDOW) begin
         xc_wr_en = 1'b1;
         xc_wr_val[wr_idx[2:0]] = w_data_reg[0];
      end
   end

   for (genvar j = 0; j < 2; j++) begin : g_irq
      localparam int B = j * `NPC_XC_STRIDE;

      // interrupt input only while its pin is plain I/O
      assign src_level[j] = (pin_cfg[j + 2].func == npc_pkg::NPC_FUNC_GPIO) ?
         pin_sync_reg[j + 2] : 1'b1;
      assign fall[j] = src_prev_reg[j] && !src_level[j];
      assign req[j] = en_reg[j] && pend_reg[j];

      always_ff @(posedge I_SYS_CLK) begin
         if (I_SRST) begin
            it_reg[j] <= 1'b0;
            en_reg[j] <= 1'b0;
            px_reg[j] <= 1'b0;
         end else if (xc_wr_en) begin
            it_reg[j] <= xc_wr_val[B + `NPC_XC_TRIGGER];
            en_reg[j] <= xc_wr_val[B + `NPC_XC_ENABLE];
            px_reg[j] <= xc_wr_val[B + `NPC_XC_PRIORITY];
         end
      end

      always_ff @(posedge I_SYS_CLK) begin
         if (I_SRST) begin
            src_prev_reg[j] <= 1'b1;
         end else begin
            src_prev_reg[j] <= src_level[j];
         end
      end

      // level mode follows the input; edge sets, service clears, set wins
      always_ff @(posedge I_SYS_CLK) begin
         if (I_SRST) begin
            pend_reg[j] <= 1'b0;
         end else if (!it_reg[j]) begin
            pend_reg[j] <= !src_level[j];
         end else if (fall[j]) begin
            pend_reg[j] <= 1'b1;
         end else if (I_IRQ_SERVICED[j]) begin
            pend_reg[j] <= 1'b0;
         end else if (xc_wr_en) begin
            pend_reg[j] <= xc_wr_val[B + `NPC_XC_PENDING];
         end
      end

      always_ff @(posedge I_SYS_CLK) begin
         if (I_SRST) begin
            irq_req_reg[j] <= 1'b0;
            irq_prio_reg[j] <= 1'b0;
         end else begin
            irq_req_reg[j] <= req[j];
            irq_prio_reg[j] <= px_reg[j];
         end
      end
   end

   // high level first, then polling position six before seven
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         vector_reg <= `NPC_VEC_NONE;
      end else if (req[0] && px_reg[0]) begin
         vector_reg <= `NPC_VEC_SECOND;
      end else if (req[1] && px_reg[1]) begin
         vector_reg <= `NPC_VEC_THIRD;
      end else if (req[0]) begin
         vector_reg <= `NPC_VEC_SECOND;
      end else if (req[1]) begin
         vector_reg <= `NPC_VEC_THIRD;
      end else begin
         vector_reg <= `NPC_VEC_NONE;
      end
   end

   assign O_S_AXI_AWREADY = awready_reg;
   assign O_S_AXI_WREADY = wready_reg;
   assign O_S_AXI_BVALID = bvalid_reg;
   assign O_S_AXI_BRESP = bresp_reg;
   assign O_S_AXI_ARREADY = arready_reg;
   assign O_S_AXI_RVALID = rvalid_reg;
   assign O_S_AXI_RDATA = rdata_reg;
   assign O_S_AXI_RRESP = rresp_reg;
   assign O_IRQ_REQ = irq_req_reg;
   assign O_IRQ_HIGH_PRIO = irq_prio_reg;
   assign O_IRQ_VECTOR = vector_reg;

   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_SRST);

   property p_edge_set;
      (it_reg[0] && src_prev_reg[0] && !src_level[0]) |=> pend_reg[0] ##1 O_IRQ_REQ[0] == en_reg[0];
   endproperty
   a_edge_set: assert property (p_edge_set) else $error("edge did not set pending");

   property p_service_clear;
      (it_reg[0] && I_IRQ_SERVICED[0] && !fall[0] && !xc_wr_en) |=> !pend_reg[0];
   endproperty
   a_service_clear: assert property (p_service_clear) else $error("service left pending");

   property p_level_follow;
      (!it_reg[1] && !xc_wr_en) |=> pend_reg[1] == !$past(src_level[1]);
   endproperty
   a_level_follow: assert property (p_level_follow) else $error("level pending wrong");

   property p_enable_gate;
      (!en_reg[0] && !xc_wr_en) [*2] |=> !O_IRQ_REQ[0];
   endproperty
   a_enable_gate: assert property (p_enable_gate) else $error("disabled irq requested");

   property p_vec_second;
      (req[0] && (px_reg[0] || !(req[1] && px_reg[1]))) |=> O_IRQ_VECTOR == `NPC_VEC_SECOND;
   endproperty
   a_vec_second: assert property (p_vec_second) else $error("second vector wrong");

   property p_vec_third;
      (req[1] && !req[0]) |=> O_IRQ_VECTOR == `NPC_VEC_THIRD;
   endproperty
   a_vec_third: assert property (p_vec_third) else $error("third vector wrong");

   property p_prio_write;
      (xc_wr_en && xc_wr_val[3]) |=> ##1 O_IRQ_HIGH_PRIO[0];
   endproperty
   a_prio_write: assert property (p_prio_write) else $error("priority not raised");

   property p_bit_write;
      (byte_wr && wr_idx == (`NPC_IDX_BIT_WINDOW + 10'h006)) |=> en_reg[1] == $past(w_data_reg[0]);
   endproperty
   a_bit_write: assert property (p_bit_write) else $error("bit write lost");

   property p_write_resp;
      (I_S_AXI_AWVALID && awready_reg && I_S_AXI_WVALID && wready_reg) |=> ##1 bvalid_reg;
   endproperty
   a_write_resp: assert property (p_write_resp) else $error("write response late");

   property p_read_resp;
      (I_S_AXI_ARVALID && arready_reg) |=> rvalid_reg && !arready_reg;
   endproperty
   a_read_resp: assert property (p_read_resp) else $error("read response late");

   c_edge_irq: cover property (it_reg[0] && fall[0] ##1 pend_reg[0] ##[1:20] I_IRQ_SERVICED[0]);
   c_bit_write: cover property (xc_wr_en && wr_idx[9:3] == 7'h20);
   c_unmapped: cover property (bvalid_reg && bresp_reg == `NPC_RESP_SLVERR);
endmodule

// ===== npc_periph_model.sv
// Far-side model of the nibble port pins: pull-ups plus peripherals that may pull low
module npc_periph_model (
   input wire logic [3:0] i_pin_out,
   input wire logic [3:0] i_pin_oe,
   input wire logic [3:0] i_pull_low,
   output logic [3:0] o_pin_level
);
   timeunit 1ns;
   timeprecision 1ns;
   // pull-up when released
   // Released pins never hold a stale value; the pull-up wins unless pulled low
   assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & ~i_pull_low);
endmodule

// ===== npc_pkg.sv
// Types shared by the nibble port files
package npc_pkg;
   typedef enum logic [1:0] {
      NPC_FUNC_GPIO,
      NPC_FUNC_RD,
      NPC_FUNC_WR,
      NPC_FUNC_RW
   } npc_func_t;

   typedef enum logic [1:0] {
      NPC_CMP_FULL,
      NPC_CMP_A1,
      NPC_CMP_A2,
      NPC_CMP_A8
   } npc_cmp_t;

   typedef struct packed {
      npc_func_t func;
      npc_cmp_t cmp;
   } npc_pin_cfg_t;

   typedef struct packed {
      logic [15:0] addr;
      logic rd_n;
      logic wr_n;
   } npc_bus_t;
endpackage

// ===== test_npc_nibble_port.sv
// Self-checking bench for the nibble port
module test_npc_nibble_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, srst, awv, wv, brdy, arv, rrdy, rdn, wrn, awr, wr, bv, arr, rv;
   logic [11:0] awa, ara;
   logic [31:0] wd, rd;
   logic [15:0] ba;
   logic [3:0] pull, lvl, po, poe;
   logic [1:0] br, rr, srv, irq, hp;
   logic [7:0] vec;
   int n_mismatch, comparisons;
   npc_nibble_port u_npc_nibble_port (.I_SYS_CLK(clk), .I_SRST(srst),
      .I_S_AXI_AWADDR(awa), .I_S_AXI_AWVALID(awv), .O_S_AXI_AWREADY(awr),
      .I_S_AXI_WDATA(wd), .I_S_AXI_WSTRB(4'hF), .I_S_AXI_WVALID(wv), .O_S_AXI_WREADY(wr),
      .O_S_AXI_BRESP(br), .O_S_AXI_BVALID(bv), .I_S_AXI_BREADY(brdy),
      .I_S_AXI_ARADDR(ara), .I_S_AXI_ARVALID(arv), .O_S_AXI_ARREADY(arr),
      .O_S_AXI_RDATA(rd), .O_S_AXI_RRESP(rr), .O_S_AXI_RVALID(rv), .I_S_AXI_RREADY(rrdy),
      .I_BUS_ADDR(ba), .I_BUS_RD_N(rdn), .I_BUS_WR_N(wrn), .I_PIN(lvl), .O_PIN(po),
      .O_PIN_OE(poe), .I_IRQ_SERVICED(srv), .O_IRQ_REQ(irq), .O_IRQ_HIGH_PRIO(hp),
      .O_IRQ_VECTOR(vec));
   npc_periph_model u_npc_periph_model (.i_pin_out(po), .i_pin_oe(poe), .i_pull_low(pull),
      .o_pin_level(lvl));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic axw(input logic [9:0] i, input logic [7:0] d, input logic [1:0] e);
      int t;
      t = 0;
      awa <= {i, 2'b00}; wd <= {24'h0, d}; awv <= 1; wv <= 1; brdy <= 1;
      do begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wr) wv <= 0;
         t++;
      end while (!bv && t < 64);
      // Bready stays up between writes; a missing response counts as a mismatch
      chk({bv, br}, {1'b1, e});
   endtask
   task automatic axr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] e);
      int t;
      t = 0;
      ara <= {i, 2'b00}; arv <= 1; rrdy <= 1;
      do begin
         @(posedge clk);
         if (arr) arv <= 0;
         t++;
      end while (!rv && t < 64);
      chk(rd, {24'h0, d});
      chk({rv, rr}, {1'b1, e});
   endtask
   // Pin 0 level launched at the first edge that sees the bus cycle
   task automatic stb(input logic [15:0] a, input logic r, input logic w, input logic e);
      ba <= a; rdn <= r; wrn <= w;
      repeat (2) @(posedge clk);
      chk(po[0], e);
      rdn <= 1; wrn <= 1;
      @(posedge clk);
   endtask
   task automatic t_reset;
      axr(10'h0C0, 8'h00, 2'h0);
      axr(10'h0C3, 8'h00, 2'h0);
      axr(10'h0D8, 8'h0F, 2'h0);
      axr(10'h3FF, 8'h00, 2'h2);
      axw(10'h3FF, 8'h55, 2'h2);
      $display("reset test done");
   endtask
   task automatic t_modes;
      axw(10'h085, 8'h12, 2'h0);
      axw(10'h084, 8'h34, 2'h0);
      for (int f = 1; f < 4; f++) begin
         axw(10'h0C2, 8'(f << 2), 2'h0);
         stb(16'h1234, 0, 1, !f[0]);
         stb(16'h1234, 1, 0, !f[1]);
         stb(16'h1234, 1, 1, 1);
         stb(16'h1235, 0, 0, 1);
         chk(poe, 4'b0001);
      end
      $display("mode test done");
   endtask
   task automatic t_cmp;
      for (int c = 0; c < 4; c++) begin
         axw(10'h0C2, 8'(12 + c), 2'h0);
         stb(16'h1235, 0, 1, c < 1);
         stb(16'h1236, 1, 0, c < 2);
         stb(16'h12FF, 0, 1, c < 3);
      end
      axw(10'h0AE, 8'h10, 2'h0);
      stb(16'h1200, 0, 1, 1);
      stb(16'h1200, 1, 1, 0);
      $display("compare test done");
   endtask
   task automatic t_gpio;
      axw(10'h0C2, 8'h00, 2'h0);
      axw(10'h0D8, 8'h0E, 2'h0);
      @(posedge clk);
      chk({poe, po}, 8'h10);
      // Pin levels need two more edges through the synchroniser
      repeat (2) @(posedge clk);
      axr(10'h0D8, 8'h0E, 2'h0);
      $display("gpio test done");
   endtask
   task automatic t_irq;
      axw(10'h0C0, 8'h0D, 2'h0);
      pull <= 4'b0100;
      repeat (8) @(posedge clk);
      pull <= 4'b0000;
      repeat (4) @(posedge clk);
      chk({irq, hp, vec}, 12'h533);
      srv <= 2'b01;
      @(posedge clk);
      srv <= 2'b00;
      repeat (4) @(posedge clk);
      chk(irq, 2'b00);
      axw(10'h0C0, 8'h40, 2'h0);
      pull <= 4'b1000;
      repeat (8) @(posedge clk);
      chk({irq, hp, vec}, 12'h83B);
      pull <= 4'b0000;
      repeat (8) @(posedge clk);
      chk(irq, 2'b00);
      axw(10'h106, 8'h00, 2'h0);
      axw(10'h103, 8'h01, 2'h0);
      axr(10'h0C0, 8'h08, 2'h0);
      $display("interrupt test done");
   endtask
   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   initial begin
      #5000000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      n_mismatch = 0; comparisons = 0;
      srst = 1; awv = 0; wv = 0; brdy = 0; arv = 0; rrdy = 0; rdn = 1; wrn = 1;
      awa = 0; ara = 0; wd = 0; ba = 0; pull = 0; srv = 0;
      repeat (16) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      t_reset();
      t_modes();
      t_cmp();
      t_gpio();
      t_irq();
      give_verdict();
   end
endmodule
